// file: rtl/timer_pin_map.svh
// Constants for the timer pin signal logic.
//
// Function
// - The output pin inverts at every counter reload unless the mode sets its own output behaviour.
// - The timer input shares its pin with the complemented timer output and counts only when the pin's alternate function is on.
// - Dual PWM output mode offers no timer input; every other mode uses the pin as the timer input.
// - In one-shot, continuous and compare modes the output equals the polarity bit while disabled and inverts at each reload once enabled.
// - In counter mode with the timer enabled the output inverts after each reload.
// - In counter mode the count advances on rising input edges with polarity 0 and on falling edges with polarity 1.
// - In single PWM mode with polarity 0 the output is low while disabled, goes high on a PWM match and low on reload.
// - In single PWM mode with polarity 1 the output is high while disabled, goes low on a PWM match and high on reload.
// - In capture mode the count is captured on rising input edges with polarity 0 and on falling edges with polarity 1.
// - In gated mode with polarity 0 the timer counts while the input is high and interrupts on its falling edge.
// - In gated mode with polarity 1 the timer counts while the input is low and interrupts on its rising edge.
// - The timer configuration alone decides whether the shared pin is the timer input or the complemented output.
// - In capture/compare mode counting starts on the first qualifying input edge, which raises no interrupt.
`ifndef TIMER_PIN_MAP_SVH
`define TIMER_PIN_MAP_SVH

// Counter width and the value loaded at every reload.
`define TMR_CNT_W     16
`define TMR_START_VAL 16'h0001

`endif

// file: rtl/timer_pin_pkg.sv
// Types shared by the timer pin signal logic.
package timer_pin_pkg;

  // Operating modes of the timer.
  typedef enum logic [3:0] {
    MODE_ONE_SHOT,
    MODE_CONTINUOUS,
    MODE_COUNTER,
    MODE_PWM_SINGLE,
    MODE_PWM_DUAL,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_GATED,
    MODE_CAPTURE_COMPARE
  } timer_mode_t;

endpackage : timer_pin_pkg

// file: rtl/timer_edge_if.sv
// Interface carrying the synchronised timer input level and its edges.
`timescale 1ns/1ps
interface timer_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input  level, input  rise, input  fall);
endinterface : timer_edge_if

// file: rtl/timer_input_sync.sv
// Two-stage synchroniser and edge detector for the shared timer input pin.
`timescale 1ns/1ps
module timer_input_sync
  import timer_pin_pkg::*;
(
  // Clock and reset.
  input  wire logic   clk_sys,
  input  wire logic   rstn,
  // Raw pin and synchronised events.
  input  wire logic   pin_raw,
  timer_edge_if.src   ev
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------

  // The first stage feeds only the second; edges come from later stages.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_raw;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Each edge shows for exactly one cycle.
  assign ev.level = st_r.sync;
  assign ev.rise  = st_r.sync & ~st_r.prev;
  assign ev.fall  = ~st_r.sync & st_r.prev;

endmodule : timer_input_sync

// file: rtl/timer_pin_signal_logic.sv
// Timer counter with output pin, shared input pin and capture logic.
`timescale 1ns/1ps
`include "timer_pin_map.svh"
module timer_pin_signal_logic
  import timer_pin_pkg::*;
#(
  parameter int CNT_W = `TMR_CNT_W
)(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Configuration from software.
  input  wire logic              timer_en,
  input  wire logic              timer_pol,
  input  wire timer_mode_t       timer_mode,
  input  wire logic              pin_alt_en,
  input  wire logic [CNT_W-1:0]  reload_val,
  input  wire logic [CNT_W-1:0]  pwm_val,
  // Timer output pin.
  output logic                   timer_zero_output,
  // Shared input / complemented output pin.
  input  wire logic              shared_pin_in,
  output logic                   shared_pin_out,
  output logic                   shared_pin_oe,
  // Status towards the core.
  output logic [CNT_W-1:0]       count_val,
  output logic [CNT_W-1:0]       capture_val,
  output logic                   capture_evt,
  output logic                   reload_evt,
  output logic                   timer_irq
);

  // Refuse counter widths that the start value and the ports cannot serve.
  if (CNT_W < 2 || CNT_W > `TMR_CNT_W) begin : g_bad_width
    $error("CNT_W out of range");
  end

  localparam logic [CNT_W-1:0] START_VAL = CNT_W'(`TMR_START_VAL);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cap;
    timer_mode_t      mode_q;
    logic             pol_q;
    logic             en_q;
    logic             out;
    logic             pin_o;
    logic             pin_oe;
    logic             started;
    logic             done;
    logic             reload;
    logic             capture;
    logic             match;
    logic             irq;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;

  timer_edge_if ev ();

  // Synchroniser for the shared pin.
  timer_input_sync u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_raw (shared_pin_in),
    .ev      (ev)
  );

  // True for modes whose output inverts at each reload.
  function automatic logic toggles(input timer_mode_t m);
    return m != MODE_PWM_SINGLE && m != MODE_PWM_DUAL;
  endfunction : toggles

  // True for the two PWM modes.
  function automatic logic is_pwm(input timer_mode_t m);
    return m == MODE_PWM_SINGLE || m == MODE_PWM_DUAL;
  endfunction : is_pwm

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------

  logic in_ok;
  logic edge_sel;
  logic edge_end;
  logic gate_on;

  // The pin is an input only when enabled and not in dual PWM mode.
  always_comb begin
    in_ok    = pin_alt_en && timer_mode != MODE_PWM_DUAL;
    edge_sel = in_ok && (timer_pol ? ev.fall : ev.rise);
    edge_end = in_ok && (timer_pol ? ev.rise : ev.fall);
    gate_on  = in_ok && (ev.level != timer_pol);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  logic tick;

  // Counting, reload, output pin and capture behaviour.
  always_comb begin
    st_nxt         = st_r;
    tick           = 1'b0;
    st_nxt.reload  = 1'b0;
    st_nxt.capture = 1'b0;
    st_nxt.match   = 1'b0;
    st_nxt.irq     = 1'b0;
    st_nxt.mode_q  = timer_mode;
    st_nxt.pol_q   = timer_pol;
    st_nxt.en_q    = timer_en;
    if (!timer_en) begin
      st_nxt.out     = timer_pol;
      st_nxt.started = 1'b0;
      st_nxt.done    = 1'b0;
    end else begin
      case (timer_mode)
        MODE_COUNTER: begin
          tick = edge_sel;
        end
        MODE_GATED: begin
          tick       = gate_on;
          st_nxt.irq = edge_end;
        end
        MODE_CAPTURE: begin
          tick = 1'b1;
          if (edge_sel) begin
            st_nxt.cap     = st_r.count;
            st_nxt.capture = 1'b1;
            st_nxt.irq     = 1'b1;
          end
        end
        MODE_CAPTURE_COMPARE: begin
          if (!st_r.started) begin
            st_nxt.started = edge_sel;
          end else begin
            tick = 1'b1;
            if (edge_sel) begin
              st_nxt.cap     = st_r.count;
              st_nxt.capture = 1'b1;
              st_nxt.irq     = 1'b1;
            end
          end
        end
        MODE_ONE_SHOT: begin
          tick = !st_r.done;
        end
        default: begin
          tick = 1'b1;
        end
      endcase
      if (tick) begin
        if (st_r.count == reload_val) begin
          st_nxt.count  = START_VAL;
          st_nxt.reload = 1'b1;
          st_nxt.irq    = 1'b1;
          if (is_pwm(timer_mode)) begin
            st_nxt.out = timer_pol;
          end else begin
            st_nxt.out = ~st_r.out;
          end
          if (timer_mode == MODE_ONE_SHOT) begin
            st_nxt.done = 1'b1;
          end
        end else begin
          st_nxt.count = st_r.count + 1'b1;
          if (is_pwm(timer_mode) && st_r.count == pwm_val) begin
            st_nxt.out   = ~timer_pol;
            st_nxt.match = 1'b1;
          end
        end
      end
    end
    // The configuration alone picks the pin's role.
    st_nxt.pin_oe = pin_alt_en && timer_mode == MODE_PWM_DUAL;
    st_nxt.pin_o  = ~st_nxt.out;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign timer_zero_output = st_r.out;
  assign shared_pin_out    = st_r.pin_o;
  assign shared_pin_oe     = st_r.pin_oe;
  assign count_val         = st_r.count;
  assign capture_val       = st_r.cap;
  assign capture_evt       = st_r.capture;
  assign reload_evt        = st_r.reload;
  assign timer_irq         = st_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_dis_pol;
    (!timer_en && timer_mode inside {MODE_ONE_SHOT, MODE_CONTINUOUS,
      MODE_COMPARE, MODE_PWM_SINGLE}) |=> st_r.out == $past(timer_pol);
  endproperty
  a_dis_pol: assert property (p_dis_pol)
    else $error("Disabled output differs from polarity.");

  property p_reload_toggle;
    (st_r.reload && toggles(st_r.mode_q)) |-> st_r.out != $past(st_r.out);
  endproperty
  a_reload_toggle: assert property (p_reload_toggle)
    else $error("Output did not invert on reload.");

  property p_pwm_reload;
    (st_r.reload && st_r.mode_q == MODE_PWM_SINGLE) |-> st_r.out == st_r.pol_q;
  endproperty
  a_pwm_reload: assert property (p_pwm_reload)
    else $error("PWM output wrong after reload.");

  property p_pwm_match;
    st_r.match |-> st_r.out == !st_r.pol_q;
  endproperty
  a_pwm_match: assert property (p_pwm_match)
    else $error("PWM output wrong after match.");

  property p_cnt_edge;
    (timer_en && timer_mode == MODE_COUNTER && !edge_sel) |=>
      $stable(st_r.count);
  endproperty
  a_cnt_edge: assert property (p_cnt_edge)
    else $error("Counter moved without a selected edge.");

  property p_capture;
    st_r.capture |-> st_r.cap == $past(st_r.count) && st_r.irq;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Captured value is not the prior count.");

  property p_gate;
    (timer_en && timer_mode == MODE_GATED && !gate_on) |=>
      $stable(st_r.count);
  endproperty
  a_gate: assert property (p_gate)
    else $error("Gated counter moved while gate closed.");

  property p_dual_pin;
    (timer_mode == MODE_PWM_DUAL && pin_alt_en) |=>
      shared_pin_oe && shared_pin_out == !timer_zero_output;
  endproperty
  a_dual_pin: assert property (p_dual_pin)
    else $error("Dual PWM pin not driving complement.");

  property p_cc_first;
    (timer_en && timer_mode == MODE_CAPTURE_COMPARE && !st_r.started &&
      edge_sel) |=> !timer_irq && !capture_evt;
  endproperty
  a_cc_first: assert property (p_cc_first)
    else $error("First capture/compare edge raised an event.");

  property p_edge_once;
    ev.rise |=> !ev.rise;
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("Rising edge seen twice.");

  c_reload:  cover property (st_r.reload && st_r.mode_q == MODE_CONTINUOUS);
  c_capture: cover property (st_r.capture);
  c_gated:   cover property (timer_irq && st_r.mode_q == MODE_GATED);
  c_pwm:     cover property (st_r.match ##[1:100] st_r.reload);

endmodule : timer_pin_signal_logic

// file: verif/timer_pin_partner.sv
// External signal source and load on the shared timer pin.
`timescale 1ns/1ps
module timer_pin_partner (
  // Level the external source wants on the pin.
  input  wire logic src_level,
  // Device side of the shared pin.
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Resolved pin level.
  output logic      pin_wire
);
  // The device owns the pin while it drives it; otherwise the source does.
  assign pin_wire = pin_oe ? pin_out : src_level;
endmodule : timer_pin_partner

// file: verif/tb.sv
// Self-checking bench for the timer pin signal logic.
`timescale 1ns/1ps
module tb;
  import timer_pin_pkg::*;
  logic        clk_sys, rstn, en, pol, alt, src;
  timer_mode_t mode;
  logic [15:0] rl, pv, cnt, cap;
  logic        out, pout, poe, pin_lvl, cevt, revt, irq, r, m_out, m_done;
  int          fail_count, cmp_count, m_cnt;
  logic [31:0] rs = 32'h0000004c;

  timer_pin_signal_logic i_timer_pin_signal_logic (
    .clk_sys(clk_sys), .rstn(rstn), .timer_en(en), .timer_pol(pol),
    .timer_mode(mode), .pin_alt_en(alt), .reload_val(rl), .pwm_val(pv),
    .timer_zero_output(out), .shared_pin_in(pin_lvl),
    .shared_pin_out(pout), .shared_pin_oe(poe), .count_val(cnt),
    .capture_val(cap), .capture_evt(cevt), .reload_evt(revt),
    .timer_irq(irq));
  timer_pin_partner i_timer_pin_partner (
    .src_level(src), .pin_out(pout), .pin_oe(poe), .pin_wire(pin_lvl));

  // 40 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Pseudo-random step from a fixed start.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Compares one value and counts the result.
  task automatic check(input logic [15:0] seen, exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Integer model of the free-running modes, compared every clock.
  task automatic model_run(input int cycles);
    repeat (cycles) begin
      @(negedge clk_sys);
      r = 1'b0;
      if (!en) begin
        m_out  = pol;
        m_done = 1'b0;
      end else if (!(mode == MODE_ONE_SHOT && m_done)) begin
        if (m_cnt == int'(rl)) begin
          r      = 1'b1;
          m_cnt  = 1;
          m_done = (mode == MODE_ONE_SHOT);
          m_out  = (mode == MODE_PWM_SINGLE) ? pol : ~m_out;
        end else begin
          if (mode == MODE_PWM_SINGLE && m_cnt == int'(pv)) m_out = ~pol;
          m_cnt++;
        end
      end
      check(cnt, 16'(m_cnt), "count");
      check(out, m_out, "output");
      check(revt, r, "reload");
    end
  endtask : model_run

  // Disables the timer, selects a mode, then runs it enabled.
  task automatic mode_run(input timer_mode_t m, input int cycles);
    en   = 1'b0;
    mode = m;
    model_run(2);
    en = 1'b1;
    model_run(cycles);
  endtask : mode_run

  // Sets a mode, moves the pin, then counts interrupts and count steps.
  task automatic hit(input timer_mode_t m, input logic p, a, lv,
                     input int ei, ed);
    logic [15:0] c0, prv;
    int          n, nc, ec;
    mode = m;
    pol  = p;
    alt  = a;
    ec   = (m == MODE_CAPTURE || m == MODE_CAPTURE_COMPARE) ? ei : 0;
    repeat (4) @(negedge clk_sys);
    c0  = cnt;
    prv = cnt;
    n   = 0;
    nc  = 0;
    src = lv;
    repeat (8) begin
      @(negedge clk_sys);
      n  += int'(irq);
      nc += int'(cevt);
      if (cevt === 1'b1) check(cap, prv, "capture value");
      prv = cnt;
    end
    check(16'(n), 16'(ei), "irq pulses");
    check(16'(nc), 16'(ec), "capture pulses");
    if (ed >= 0) check(cnt - c0, 16'(ed), "count step");
  endtask : hit

  // Cuts a hang short.
  initial begin
    #150000;
    fail_count++;
    print_verdict();
  end

  // Main sequence: continuous model, idle levels, then pin events.
  initial begin
    {rstn, en, pol, alt, src} = '0;
    mode = MODE_CONTINUOUS;
    rl   = 16'h0002;
    pv   = 16'h0003;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    rs   = xs(rs);
    pol  = rs[0];
    rl   = 16'h0002 + 16'(rs[3:1]);
    @(negedge clk_sys);
    check(out, pol, "idle level");
    m_cnt  = 0;
    m_out  = pol;
    m_done = 1'b0;
    en     = 1'b1;
    model_run(40);
    en   = 1'b0;
    mode = MODE_PWM_SINGLE;
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      repeat (2) @(negedge clk_sys);
      check(out, pol, "pwm idle");
    end
    rl = 16'hffff;
    en = 1'b1;
    hit(MODE_COUNTER, 0, 1, 1, 0, 1);
    hit(MODE_COUNTER, 0, 1, 0, 0, 0);
    hit(MODE_COUNTER, 1, 1, 1, 0, 0);
    hit(MODE_COUNTER, 1, 1, 0, 0, 1);
    hit(MODE_CAPTURE, 0, 1, 1, 1, -1);
    hit(MODE_CAPTURE, 0, 1, 0, 0, -1);
    hit(MODE_CAPTURE, 1, 1, 1, 0, -1);
    hit(MODE_CAPTURE, 1, 1, 0, 1, -1);
    hit(MODE_CAPTURE, 0, 0, 1, 0, -1);
    hit(MODE_CAPTURE, 0, 0, 0, 0, -1);
    hit(MODE_PWM_DUAL, 0, 1, 1, 0, -1);
    check(poe, 1'b1, "dual drives pin");
    check(pout, !out, "complement pin");
    hit(MODE_GATED, 0, 1, 1, 0, -1);
    hit(MODE_GATED, 0, 1, 0, 1, -1);
    hit(MODE_GATED, 0, 1, 0, 0, 0);
    hit(MODE_GATED, 1, 1, 1, 1, -1);
    hit(MODE_GATED, 1, 1, 1, 0, 0);
    en = 1'b0;
    hit(MODE_CAPTURE_COMPARE, 0, 1, 0, 0, -1);
    en = 1'b1;
    hit(MODE_CAPTURE_COMPARE, 0, 1, 1, 0, -1);
    hit(MODE_CAPTURE_COMPARE, 0, 1, 0, 0, -1);
    hit(MODE_CAPTURE_COMPARE, 0, 1, 1, 1, -1);
    // Mid-run reset, then PWM, one-shot and compare runs under the model.
    rstn = 1'b0;
    en   = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn  = 1'b1;
    rs    = xs(rs);
    pol   = rs[4];
    rl    = 16'h0005 + 16'(rs[7:5]);
    pv    = 16'h0001 + 16'(rs[9:8]);
    m_cnt = 0;
    mode_run(MODE_PWM_SINGLE, 30);
    mode_run(MODE_ONE_SHOT, 30);
    mode_run(MODE_COMPARE, 20);
    print_verdict();
  end
endmodule : tb
